// File: rtl/sdw_pkg.sv
`default_nettype none
package sdw_pkg;
    localparam int WORD_BITS = 16;
    localparam int CMD_BITS  = 4;
    localparam int DATA_BITS = 12;
    // resolution variant: 8, 10 or 12
    localparam int RES_BITS  = 12;
    localparam int CMD_MSB   = 15;
    localparam int CMD_LSB   = 12;
    localparam int DATA_MSB  = 11;

    localparam logic [4:0] CNT_LAST = 5'h0F;
    localparam logic [4:0] CNT_FULL = 5'h10;

    localparam logic [3:0] CMD_NOP       = 4'h0;
    localparam logic [3:0] CMD_LOAD      = 4'h1;
    localparam logic [3:0] CMD_READBACK  = 4'h2;
    localparam logic [3:0] CMD_CHAIN_OFF = 4'h9;
    localparam logic [3:0] CMD_RISE_EDGE = 4'hA;
    localparam logic [3:0] CMD_ZERO      = 4'hB;
    localparam logic [3:0] CMD_MID       = 4'hC;

    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_CODE     = 8'h08;
    localparam logic [7:0] REG_READBACK = 8'h0C;
    localparam logic [7:0] REG_FRAMES   = 8'h10;

    localparam int CTRL_ACCEPT_BIT = 0;
    localparam int ST_CHAIN_BIT    = 0;
    localparam int ST_RISE_BIT     = 1;
    localparam int ST_FRAME_BIT    = 2;
    localparam int ST_RSVD_BIT     = 3;

    localparam logic        CTRL_ACCEPT_RST = 1'b1;
    localparam logic        CHAIN_EN_RST    = 1'b1;
    localparam logic        RISE_EDGE_RST   = 1'b0;
    localparam logic [11:0] ZERO_CODE       = 12'h000;
    localparam logic [11:0] MID_CODE        = 12'h800;
    localparam logic [11:0] DATA_MASK       = 12'hFFF << (DATA_BITS - RES_BITS);

    typedef enum logic [1:0] {FR_IDLE, FR_SHIFT, FR_DONE} sdw_frame_type;

    function automatic logic [11:0] dac_trim(input logic [11:0] d);
        return d & DATA_MASK;
    endfunction

    function automatic logic cmd_reserved(input logic [3:0] c);
        return !(c inside {CMD_NOP, CMD_LOAD, CMD_READBACK, CMD_CHAIN_OFF,
                           CMD_RISE_EDGE, CMD_ZERO, CMD_MID});
    endfunction
endpackage
`default_nettype wire

// File: rtl/sdw_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdw_reg_if;
    logic        wr;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [3:0]  sel;
    logic [31:0] rdat;
    modport bus  (output wr, adr, wdat, sel, input rdat);
    modport core (input wr, adr, wdat, sel, output rdat);
endinterface

interface sdw_link_if;
    logic [15:0] neg_sr;
    logic [15:0] pos_sr;
    logic        neg_done;
    logic        pos_done;
    logic        chain_en;
    logic        rise_mode;
    modport link (output neg_sr, pos_sr, neg_done, pos_done, input chain_en, rise_mode);
    modport core (input neg_sr, pos_sr, neg_done, pos_done, output chain_en, rise_mode);
endinterface
`default_nettype wire

// File: rtl/sdw_link.sv
`timescale 1ns/1ps
`default_nettype none
module sdw_link
    import sdw_pkg::*;
(
    input  wire logic  sclk_i,
    input  wire logic  frame_n_i,
    input  wire logic  din_i,
    output logic       chain_data_out_o,
    sdw_link_if.link   lk
);
    logic [4:0]  ncnt_q;
    logic [4:0]  pcnt_q;
    logic [15:0] nsr_q;
    logic [15:0] psr_q;

    // both edges are captured; the core picks the active one by its edge mode bit
    // frame high holds counters cleared, so stray clocks are ignored
    always_ff @(negedge sclk_i or posedge frame_n_i)
    begin
        if (frame_n_i)
            ncnt_q <= 5'h00;
        else if (ncnt_q != CNT_FULL)
            ncnt_q <= ncnt_q + 5'h01;
    end

    always_ff @(posedge sclk_i or posedge frame_n_i)
    begin
        if (frame_n_i)
            pcnt_q <= 5'h00;
        else if (pcnt_q != CNT_FULL)
            pcnt_q <= pcnt_q + 5'h01;
    end

    // msb first; chain mode keeps shifting past sixteen
    always_ff @(negedge sclk_i)
    begin
        if (!frame_n_i && (lk.chain_en || ncnt_q != CNT_FULL))
            nsr_q <= {nsr_q[14:0], din_i};
    end

    always_ff @(posedge sclk_i)
    begin
        if (!frame_n_i && (lk.chain_en || pcnt_q != CNT_FULL))
            psr_q <= {psr_q[14:0], din_i};
    end

    // level held until frame rises, so a short core sync cannot miss it
    always_ff @(negedge sclk_i or posedge frame_n_i)
    begin
        if (frame_n_i)
            lk.neg_done <= 1'b0;
        else if (ncnt_q == CNT_LAST)
            lk.neg_done <= 1'b1;
    end

    always_ff @(posedge sclk_i or posedge frame_n_i)
    begin
        if (frame_n_i)
            lk.pos_done <= 1'b0;
        else if (pcnt_q == CNT_LAST)
            lk.pos_done <= 1'b1;
    end

    // overflow bit leaves on the rising edge, opposite the sampling one only in falling-edge mode
    always_ff @(posedge sclk_i or posedge frame_n_i)
    begin
        if (frame_n_i)
            chain_data_out_o <= 1'b0;
        else
            chain_data_out_o <= lk.rise_mode ? psr_q[15] : nsr_q[15];
    end

    assign lk.neg_sr = nsr_q;
    assign lk.pos_sr = psr_q;
endmodule
`default_nettype wire

// File: rtl/sdw_wb.sv
`timescale 1ns/1ps
`default_nettype none
module sdw_wb
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    sdw_reg_if.bus           rg
);
    logic req_w;

    assign req_w   = wb_cyc_i && wb_stb_i;
    // write lands on the same edge the master samples ack
    assign rg.wr   = req_w && wb_we_i && wb_ack_o;
    assign rg.adr  = wb_adr_i;
    assign rg.wdat = wb_dat_i;
    assign rg.sel  = wb_sel_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req_w && !wb_ack_o;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (req_w && !wb_ack_o)
            wb_dat_o <= wb_we_i ? 32'h0000_0000 : rg.rdat;
    end
endmodule
`default_nettype wire

// File: rtl/sdw_top.sv
`timescale 1ns/1ps
`default_nettype none
module sdw_top
    import sdw_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sclk_i,
    input  wire logic        frame_n_i,
    input  wire logic        din_i,
    output logic             chain_data_out_o,
    output logic      [11:0] dac_code_o,
    output logic             buf_power_o
);
    sdw_reg_if  rg ();
    sdw_link_if lk ();

    sdw_wb u_wb
    (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .rg       (rg.bus)
    );

    sdw_link u_link
    (
        .sclk_i           (sclk_i),
        .frame_n_i        (frame_n_i),
        .din_i            (din_i),
        .chain_data_out_o (chain_data_out_o),
        .lk               (lk.link)
    );

    logic          fr_s1_q;
    logic          fr_s2_q;
    logic          fr_s3_q;
    logic          nd_s1_q;
    logic          nd_s2_q;
    logic          nd_s3_q;
    logic          pd_s1_q;
    logic          pd_s2_q;
    logic          pd_s3_q;
    logic          fall_evt_w;
    logic          rise_evt_w;
    logic          done_evt_w;
    sdw_frame_type state_q;
    sdw_frame_type state_d;
    logic          accept_q;
    logic          chain_en_q;
    logic          rise_q;
    logic [11:0]   dac_q;
    logic [11:0]   readback_q;
    logic          rsvd_q;
    logic [15:0]   frames_q;
    logic          buf_power_q;
    logic          apply_w;
    logic [15:0]   word_w;
    logic [3:0]    cmd_w;
    logic [11:0]   data_w;
    logic [31:0]   rdat_w;
    logic          status_wr_w;

    // frame select is a pin: two stages before any logic, third for edges
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fr_s1_q <= 1'b1;
            fr_s2_q <= 1'b1;
            fr_s3_q <= 1'b1;
        end
        else
        begin
            fr_s1_q <= frame_n_i;
            fr_s2_q <= fr_s1_q;
            fr_s3_q <= fr_s2_q;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            nd_s1_q <= 1'b0;
            nd_s2_q <= 1'b0;
            nd_s3_q <= 1'b0;
            pd_s1_q <= 1'b0;
            pd_s2_q <= 1'b0;
            pd_s3_q <= 1'b0;
        end
        else
        begin
            nd_s1_q <= lk.neg_done;
            nd_s2_q <= nd_s1_q;
            nd_s3_q <= nd_s2_q;
            pd_s1_q <= lk.pos_done;
            pd_s2_q <= pd_s1_q;
            pd_s3_q <= pd_s2_q;
        end
    end

    assign fall_evt_w = fr_s3_q && !fr_s2_q;
    assign rise_evt_w = !fr_s3_q && fr_s2_q;
    assign done_evt_w = rise_q ? (pd_s2_q && !pd_s3_q) : (nd_s2_q && !nd_s3_q);

    // shift registers are quiet here: the clock stopped counting at sixteen
    // or the frame already ended, which the host keeps ordered
    assign word_w = rise_q ? lk.pos_sr : lk.neg_sr;
    assign cmd_w  = word_w[CMD_MSB:CMD_LSB];
    assign data_w = word_w[DATA_MSB:0];

    // frame end applies while the port is open, even when short standalone also
    // applies on the sixteenth edge and then ignores the rest
    assign apply_w = accept_q && (state_q == FR_SHIFT)
                     && (rise_evt_w || (done_evt_w && !chain_en_q));

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            FR_IDLE:
                if (fall_evt_w)
                    state_d = FR_SHIFT;
            FR_SHIFT:
                if (rise_evt_w)
                    state_d = FR_IDLE;
                else if (done_evt_w && !chain_en_q)
                    state_d = FR_DONE;
            FR_DONE:
                if (rise_evt_w)
                    state_d = FR_IDLE;
            default:
                state_d = FR_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_q <= FR_IDLE;
        else
            state_q <= state_d;
    end

    // buffers follow frame select
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            buf_power_q <= 1'b0;
        else
            buf_power_q <= !fr_s2_q;
    end

    // converter register: zero scale after reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dac_q <= ZERO_CODE;
        else if (apply_w)
        begin
            unique case (cmd_w)
                CMD_LOAD: dac_q <= dac_trim(data_w);
                CMD_ZERO: dac_q <= ZERO_CODE;
                CMD_MID:  dac_q <= MID_CODE;
                default:  dac_q <= dac_q;
            endcase
        end
    end

    // chaining only returns with a reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            chain_en_q <= CHAIN_EN_RST;
        else if (apply_w && cmd_w == CMD_CHAIN_OFF)
            chain_en_q <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rise_q <= RISE_EDGE_RST;
        else if (apply_w && cmd_w == CMD_RISE_EDGE)
            rise_q <= 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            readback_q <= ZERO_CODE;
        else if (apply_w && cmd_w == CMD_READBACK)
            readback_q <= dac_q;
    end

    // reserved codes only leave a sticky mark and bump the frame count; set beats clear
    assign status_wr_w = rg.wr && rg.adr == REG_STATUS && rg.sel[0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rsvd_q <= 1'b0;
        else if (apply_w && cmd_reserved(cmd_w))
            rsvd_q <= 1'b1;
        else if (status_wr_w && rg.wdat[ST_RSVD_BIT])
            rsvd_q <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            frames_q <= 16'h0000;
        else if (apply_w)
            frames_q <= frames_q + 16'h0001;
    end

    // software may close the port; frames are then counted nowhere
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            accept_q <= CTRL_ACCEPT_RST;
        else if (rg.wr && rg.adr == REG_CTRL && rg.sel[0])
            accept_q <= rg.wdat[CTRL_ACCEPT_BIT];
    end

    always_comb
    begin
        rdat_w = 32'h0000_0000;
        unique case (rg.adr)
            REG_CTRL:
                rdat_w[CTRL_ACCEPT_BIT] = accept_q;
            REG_STATUS:
            begin
                rdat_w[ST_CHAIN_BIT] = chain_en_q;
                rdat_w[ST_RISE_BIT]  = rise_q;
                rdat_w[ST_FRAME_BIT] = buf_power_q;
                rdat_w[ST_RSVD_BIT]  = rsvd_q;
            end
            REG_CODE:
                rdat_w[11:0] = dac_q;
            REG_READBACK:
                rdat_w[11:0] = readback_q;
            REG_FRAMES:
                rdat_w[15:0] = frames_q;
            default:
                rdat_w = 32'h0000_0000;
        endcase
    end

    assign rg.rdat      = rdat_w;
    assign lk.chain_en  = chain_en_q;
    assign lk.rise_mode = rise_q;
    assign dac_code_o   = dac_q;
    assign buf_power_o  = buf_power_q;

    chk_zero_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        apply_w && cmd_w == CMD_ZERO |=> dac_q == ZERO_CODE
    ) else $error("zero-scale clear did not reach the converter");

    chk_mid_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        apply_w && cmd_w == CMD_MID |=> dac_q == MID_CODE
    ) else $error("midscale clear did not reach the converter");

    chk_load_trim: assert property (
        @(posedge clk_i) disable iff (rst_i)
        apply_w && cmd_w == CMD_LOAD |=> dac_q == dac_trim($past(data_w))
    ) else $error("load did not copy the trimmed data field");

    chk_low_bits_drop: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (dac_q & ~DATA_MASK) == 12'h000
    ) else $error("bits below the resolution reached the converter");

    chk_chain_sticky: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !chain_en_q |=> !chain_en_q
    ) else $error("chaining came back without a reset");

    chk_partial_latch: assert property (
        @(posedge clk_i) disable iff (rst_i)
        accept_q && state_q == FR_SHIFT && rise_evt_w |-> apply_w ##1 state_q == FR_IDLE
    ) else $error("short frame was dropped");

    chk_standalone_xfer: assert property (
        @(posedge clk_i) disable iff (rst_i)
        accept_q && !chain_en_q && state_q == FR_SHIFT && done_evt_w
        |-> apply_w ##1 (state_q == FR_DONE || state_q == FR_IDLE)
    ) else $error("standalone word not applied at sixteenth edge");

    chk_chain_waits: assert property (
        @(posedge clk_i) disable iff (rst_i)
        chain_en_q && !rise_evt_w |-> !apply_w
    ) else $error("chain mode applied before frame end");

    chk_power_up: assert property (
        @(posedge clk_i) disable iff (rst_i)
        fall_evt_w |-> ##[1:2] buf_power_q
    ) else $error("buffers not powered after frame start");

    chk_power_down: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rise_evt_w |=> !buf_power_q ##1 state_q != FR_SHIFT
    ) else $error("buffers stayed powered after frame end");

    chk_nop_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        apply_w && cmd_w == CMD_NOP |=> $stable(dac_q) && $stable(rise_q) && $stable(chain_en_q)
    ) else $error("no-operation changed device state");

    chk_idle_quiet: assert property (
        @(posedge clk_i) disable iff (rst_i)
        state_q != FR_SHIFT |-> !apply_w
    ) else $error("word applied outside an open frame");
endmodule
`default_nettype wire

// File: testbench/sdw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdw_host_model
(
    input  wire logic chain_i,
    output logic      sclk_o,
    output logic      frame_n_o,
    output logic      din_o
);
    logic [31:0] cap_q;

    initial
    begin
        sclk_o    = 1'b1;
        frame_n_o = 1'b0;
        din_o     = 1'b0;
        cap_q     = '0;
        // a clean rise clears the link counters, which have no reset of their own
        #1 frame_n_o = 1'b1;
    end

    // select and clock come from one timing source, clock parked high outside frames
    task automatic send(input logic [31:0] w, input int nbits);
        #3 frame_n_o = 1'b0;
        #16;
        for (int i = nbits - 1; i >= 0; i--) // one bit per pulse
        begin
            din_o = w[i]; // msb first, command on top
            #8 sclk_o = 1'b0;
            cap_q = {cap_q[30:0], chain_i};
            // data held over both edges so either sampling edge sees it
            #16 sclk_o = 1'b1;
            #8;
        end
        #8 frame_n_o = 1'b1;
        // a released line must not keep showing its last bit
        din_o = ~din_o;
        #40;
    endtask

    // clock and data noise while deselected
    task automatic wiggle(input int n);
        repeat (n)
        begin
            din_o = ~din_o;
            #16 sclk_o = 1'b0;
            #16 sclk_o = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// File: testbench/sdw_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sdw_top_tb
    import sdw_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        sclk;
    logic        frame_n;
    logic        din;
    logic        chain_out;
    logic [11:0] dac_code;
    logic        buf_power;
    int          fails = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [15:0] cmd_words [5] = '{{CMD_ZERO, 12'hFFF}, {CMD_LOAD, 12'h3C3},
        {CMD_MID, 12'h123}, {CMD_NOP, 12'hFFF}, {CMD_READBACK, 12'h000}};
    logic [11:0] cmd_exp [5] = '{ZERO_CODE, 12'h3C3, MID_CODE, MID_CODE, MID_CODE};
    logic [3:0]  rsv_codes [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hD, 4'hE, 4'hF};

    always #4 clk_i = ~clk_i;

    sdw_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sclk_i(sclk), .frame_n_i(frame_n),
        .din_i(din), .chain_data_out_o(chain_out), .dac_code_o(dac_code),
        .buf_power_o(buf_power));

    sdw_host_model host (.chain_i(chain_out), .sclk_o(sclk), .frame_n_o(frame_n),
        .din_o(din));

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            $display("mismatch at %0t: run too long", $time);
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // classic cycle: held until ack is seen high, released right after that edge
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        n = 0;
        rd = '0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= a;
        wb_sel <= 4'hF;
        wb_dat <= wd;
        // ack and read data are taken at the one rising edge that sees ack high
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 64);
        rd = wb_dat_o;
        if (wb_ack_o !== 1'b1)
        begin
            fails++;
            $display("mismatch at %0t: no bus answer", $time);
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] d;
        wb_xfer(1'b0, a, 32'h0, d);
        chk(d, exp, msg);
    endtask

    // apply lands a few clocks after select rises, or after the sixteenth edge when standalone; 8 clocks covers the worst case
    task automatic frame(input logic [31:0] w, input int nbits, input logic [11:0] exp,
        input string msg);
        host.send(w, nbits);
        repeat (8) @(posedge clk_i);
        chk({20'h0, dac_code}, {20'h0, exp & DATA_MASK}, msg);
    endtask

    initial
    begin
        logic [31:0] junk;
        rst_i  = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we  = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_dat = 32'h0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk({20'h0, dac_code}, 32'h0, "reset code");
        chk({31'h0, buf_power}, 32'h0, "reset power");
        rd_chk(REG_STATUS, 32'h1 << ST_CHAIN_BIT, "reset status");
        rd_chk(REG_CTRL, 32'h1, "reset ctrl");
        rd_chk(8'hFC, 32'h0, "unmapped");
        frame({16'h1234, CMD_LOAD, 12'hABC}, 32, 12'hABC, "chain load");
        chk({16'h0, host.cap_q[15:0]}, 32'h1234, "chain out");
        rd_chk(REG_CODE, {20'h0, 12'hABC & DATA_MASK}, "code reg");
        fork
            frame({CMD_LOAD, 12'h5A5}, 16, 12'h5A5, "load");
            begin
                repeat (30) @(posedge clk_i);
                chk({31'h0, buf_power}, 32'h1, "power in frame");
            end
        join
        chk({31'h0, buf_power}, 32'h0, "power after frame");
        for (int i = 0; i < 5; i++)
            frame({16'h0, cmd_words[i]}, 16, cmd_exp[i], "command");
        rd_chk(REG_READBACK, {20'h0, MID_CODE & DATA_MASK}, "readback");
        host.wiggle(20);
        repeat (8) @(posedge clk_i);
        chk({20'h0, dac_code}, {20'h0, MID_CODE & DATA_MASK}, "deselected noise");
        chk({31'h0, chain_out}, 32'h0, "deselected chain out");
        for (int i = 0; i < 9; i++)
            frame({16'h0, rsv_codes[i], 12'hFFF}, 16, MID_CODE, "reserved");
        rd_chk(REG_STATUS, 32'h9, "reserved flag");
        wb_xfer(1'b1, REG_STATUS, 32'h8, junk);
        rd_chk(REG_STATUS, 32'h1, "flag cleared");
        frame({CMD_MID, 12'h010}, 16, MID_CODE, "mid");
        // partial frame: old low byte becomes command and high data bits
        frame(32'h5A, 8, 12'h05A, "short frame");
        frame({CMD_CHAIN_OFF, 12'h000}, 16, 12'h05A, "chain off");
        rd_chk(REG_STATUS, 32'h0, "status standalone");
        frame({CMD_LOAD, 12'h777, 4'hF}, 20, 12'h777, "extra bits");
        frame({CMD_RISE_EDGE, 12'h000}, 16, 12'h777, "rise mode");
        rd_chk(REG_STATUS, 32'h2, "status rise");
        frame({CMD_LOAD, 12'h1E1}, 16, 12'h1E1, "rise load");
        // closed port: frame ignored and not counted; reset must reopen it
        wb_xfer(1'b1, REG_CTRL, 32'h0, junk);
        frame({CMD_LOAD, 12'h2D2}, 16, 12'h1E1, "port closed");
        rd_chk(REG_FRAMES, 32'h16, "frame count");
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk({20'h0, dac_code}, 32'h0, "second reset code");
        rd_chk(REG_STATUS, 32'h1, "second reset status");
        rd_chk(REG_CTRL, 32'h1, "second reset ctrl");
        end_sim();
    end
endmodule
`default_nettype wire
